// ===== include/interlock_cfg.svh
// Constants for the dual-channel torque-off interlock: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef INTERLOCK_CFG_SVH
`define INTERLOCK_CFG_SVH

// Register byte offsets on the AHB-Lite slave.
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_IRQ_STATUS 4'h8
`define ADDR_IRQ_MASK 4'hC

// Control register fields.
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'h0

// Status register fields.
`define STAT_PERMIT_BIT 0
`define STAT_ALARM_BIT 1
`define STAT_PASSED_BIT 2
`define STAT_FAILED_BIT 3
`define STAT_JUMPER_BIT 4
`define STAT_INPUT_A_BIT 5
`define STAT_INPUT_B_BIT 6

// Interrupt status and mask fields.
`define IRQ_MISMATCH_BIT 0
`define IRQ_TEST_FAIL_BIT 1
`define IRQ_TORQUE_OFF_BIT 2
`define IRQ_WIDTH 3
`define IRQ_MASK_RESET 3'h0

// Synchroniser lanes: input A, input B, bypass jumper, self-test echo.
`define SYNC_WIDTH 4
`define LANE_A 0
`define LANE_B 1
`define LANE_JUMPER 2
`define LANE_ECHO 3

// Power stage gate drive count.
`define GATE_WIDTH 6

// Self-test settle time per phase.
`define CLK_MHZ 100
`define TEST_SETTLE_NS 1000
`define TEST_SETTLE_CYCLES ((`TEST_SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== include/interlock_pkg.sv
// Types for the dual-channel torque-off interlock.
// Assumes interlock_cfg.svh sits on the include path.
`include "interlock_cfg.svh"

package interlock_pkg;

    typedef enum logic [2:0] {
        SELF_TEST_HIGH,
        SELF_TEST_LOW,
        WAIT_INPUTS,
        RUN,
        TEST_FAILED
    } interlock_state_t;

    typedef logic [`GATE_WIDTH-1:0] gate_t;
    typedef logic [`IRQ_WIDTH-1:0] irq_t;

    typedef struct packed {
        interlock_state_t fsm;
        logic [7:0] count;
        logic testDrive;
        logic testPassed;
        logic bothPrev;
        logic alarm;
        logic permitPrev;
        gate_t gate;
        logic ctrlEnable;
        irq_t irqStatus;
        irq_t irqMask;
        logic dataPhaseWrite;
        logic [3:0] dataPhaseAddr;
        logic [31:0] readData;
    } interlock_regs_t;

endpackage

// ===== rtl/input_synchronizer.sv
// Two-flop synchroniser for the asynchronous interlock inputs.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ps
`include "interlock_cfg.svh"

module input_synchronizer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Lanes
    input wire logic [`SYNC_WIDTH-1:0] rawIn,
    output logic [`SYNC_WIDTH-1:0] syncOut
);

    logic [`SYNC_WIDTH-1:0] stageOne;

    // One pair of flops per lane; reset to low so an input reads inactive.
    genvar lane;
    generate
        for (lane = 0; lane < `SYNC_WIDTH; lane = lane + 1) begin : g_lane
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stageOne[lane] <= 1'b0;
                    syncOut[lane] <= 1'b0;
                end else begin
                    stageOne[lane] <= rawIn[lane];
                    syncOut[lane] <= stageOne[lane];
                end
            end
        end
    endgenerate

endmodule

// ===== rtl/dual_channel_torque_off_interlock.sv
// Dual-channel torque-off interlock with self-test, alarm and AHB-Lite registers.
// Assumes the safety inputs, jumper and echo are asynchronous levels, and that
// the AHB-Lite master issues single word transfers to this one slave.
//
// Functional notes
// - Power stage enabled only with both inputs high.
// - One input high: outputs off, mismatch alarm.
// - Self-test at power-up and both-inputs rise.
// - Energize only after self-test passed.
// - Any interlock failure cuts the power stage.
// - Inputs act on gates and alarm only unbypassed and enabled.
// - Torque removal floats motor, all drives off.
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "interlock_cfg.svh"

module dual_channel_torque_off_interlock
    import interlock_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Safety inputs and bypass jumper
    input wire logic safetyInputA,
    input wire logic safetyInputB,
    input wire logic bypassJumperFitted,
    // Interlock path self-test
    output logic testStimulus,
    input wire logic testEcho,
    // Power stage
    input wire interlock_pkg::gate_t gateCommand,
    output interlock_pkg::gate_t gateDrive,
    output logic safeTorqueRemoval,
    output logic safetyChannelMismatchAlarm,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt
    output logic irq
);

    import interlock_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------

    logic [`SYNC_WIDTH-1:0] syncIn;

    // Every asynchronous level is brought onto clk before it is judged.
    input_synchronizer u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .rawIn({testEcho, bypassJumperFitted, safetyInputB, safetyInputA}),
        .syncOut(syncIn)
    );

    logic inA;
    logic inB;
    logic jumper;
    logic echo;

    // Named views of the synchronised lanes.
    assign inA = syncIn[`LANE_A];
    assign inB = syncIn[`LANE_B];
    assign jumper = syncIn[`LANE_JUMPER];
    assign echo = syncIn[`LANE_ECHO];

    // ------------------------------------------------------------------
    // Interlock decisions
    // ------------------------------------------------------------------

    interlock_regs_t cur;
    interlock_regs_t next_cur;

    logic effective;
    logic bothHigh;
    logic bothRise;
    logic permit;
    logic settled;

    // The inputs steer only the test sequence until the jumper is out and software enables.
    assign effective = cur.ctrlEnable & ~jumper;
    assign bothHigh = inA & inB;
    assign bothRise = bothHigh & ~cur.bothPrev;
    assign settled = (cur.count == 8'(`TEST_SETTLE_CYCLES - 1));

    // When effective, permission needs a passed test and both inputs high at once; otherwise it is always given.
    assign permit = effective ? ((cur.fsm == RUN) & bothHigh) : 1'b1;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------

    logic accept;
    logic mapped;
    logic readIrq;
    logic [31:0] statusWord;

    // A transfer is taken in its address phase; the slave never stalls.
    assign accept = hsel & htrans[1] & hready;
    assign mapped = (haddr[31:4] == 28'h0000000) & (haddr[1:0] == 2'h0);
    assign readIrq = accept & ~hwrite & mapped & (haddr[3:0] == `ADDR_IRQ_STATUS);

    // Live status word, built from the block's own state.
    always_comb begin
        statusWord = 32'h00000000;
        statusWord[`STAT_PERMIT_BIT] = permit;
        statusWord[`STAT_ALARM_BIT] = cur.alarm;
        statusWord[`STAT_PASSED_BIT] = cur.testPassed;
        statusWord[`STAT_FAILED_BIT] = (cur.fsm == TEST_FAILED);
        statusWord[`STAT_JUMPER_BIT] = jumper;
        statusWord[`STAT_INPUT_A_BIT] = inA;
        statusWord[`STAT_INPUT_B_BIT] = inB;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    irq_t events;

    // One process computes the whole next state of the block.
    always_comb begin
        next_cur = cur;
        events = '0;
        next_cur.bothPrev = bothHigh;
        next_cur.permitPrev = permit;

        // Alarm follows a disagreement and clears once both agree again.
        next_cur.alarm = effective & (inA ^ inB);

        // Outputs are forced off rather than braked, so the motor floats.
        next_cur.gate = permit ? gateCommand : '0;

        // Self-test sequence: drive the path high, then low, checking the echo.
        case (cur.fsm)
            SELF_TEST_HIGH: begin
                next_cur.testDrive = 1'b1;
                next_cur.count = cur.count + 8'h01;
                if (settled) begin
                    next_cur.count = 8'h00;
                    next_cur.fsm = echo ? SELF_TEST_LOW : TEST_FAILED;
                end
            end
            SELF_TEST_LOW: begin
                next_cur.testDrive = 1'b0;
                next_cur.count = cur.count + 8'h01;
                if (settled) begin
                    next_cur.count = 8'h00;
                    next_cur.testPassed = ~echo;
                    if (echo) begin
                        next_cur.fsm = TEST_FAILED;
                    end else begin
                        next_cur.fsm = bothHigh ? RUN : WAIT_INPUTS;
                    end
                end
            end
            WAIT_INPUTS: begin
                next_cur.testDrive = 1'b0;
                if (bothHigh && cur.testPassed) begin
                    next_cur.fsm = RUN;
                end
            end
            RUN: begin
                next_cur.testDrive = 1'b0;
                if (!bothHigh) begin
                    next_cur.fsm = WAIT_INPUTS;
                end
            end
            TEST_FAILED: begin
                next_cur.testDrive = 1'b0;
                next_cur.testPassed = 1'b0;
            end
            default: begin
                next_cur.fsm = TEST_FAILED;
                next_cur.testDrive = 1'b0;
            end
        endcase

        // A fresh rise of both inputs always restarts the test.
        if (bothRise) begin
            next_cur.fsm = SELF_TEST_HIGH;
            next_cur.count = 8'h00;
            next_cur.testPassed = 1'b0;
            next_cur.testDrive = 1'b1;
        end

        // Sticky events; a read clears, but a same-cycle event still lands.
        events[`IRQ_MISMATCH_BIT] = next_cur.alarm & ~cur.alarm;
        events[`IRQ_TEST_FAIL_BIT] = (next_cur.fsm == TEST_FAILED) &
            (cur.fsm != TEST_FAILED);
        events[`IRQ_TORQUE_OFF_BIT] = cur.permitPrev & ~permit;
        next_cur.irqStatus = (readIrq ? '0 : cur.irqStatus) | events;

        // Write data phase lands on the address kept from the address phase.
        next_cur.dataPhaseWrite = accept & hwrite & mapped;
        next_cur.dataPhaseAddr = haddr[3:0];
        if (cur.dataPhaseWrite) begin
            case (cur.dataPhaseAddr)
                `ADDR_CONTROL: next_cur.ctrlEnable = hwdata[`CTRL_ENABLE_BIT];
                `ADDR_IRQ_MASK: next_cur.irqMask = hwdata[`IRQ_WIDTH-1:0];
                default: begin
                end
            endcase
        end

        // Read data is latched at the address phase to stand in the data phase.
        if (accept && !hwrite) begin
            next_cur.readData = 32'h00000000;
            if (mapped) begin
                case (haddr[3:0])
                    `ADDR_CONTROL: next_cur.readData[`CTRL_ENABLE_BIT] = cur.ctrlEnable;
                    `ADDR_STATUS: next_cur.readData = statusWord;
                    `ADDR_IRQ_STATUS: next_cur.readData[`IRQ_WIDTH-1:0] = cur.irqStatus;
                    `ADDR_IRQ_MASK: next_cur.readData[`IRQ_WIDTH-1:0] = cur.irqMask;
                    default: next_cur.readData = 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Reset starts the power-up self-test with the stage off.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur.fsm <= SELF_TEST_HIGH;
            cur.count <= 8'h00;
            cur.testDrive <= 1'b0;
            cur.testPassed <= 1'b0;
            cur.bothPrev <= 1'b0;
            cur.alarm <= 1'b0;
            cur.permitPrev <= 1'b0;
            cur.gate <= '0;
            cur.ctrlEnable <= `CTRL_RESET;
            cur.irqStatus <= '0;
            cur.irqMask <= `IRQ_MASK_RESET;
            cur.dataPhaseWrite <= 1'b0;
            cur.dataPhaseAddr <= 4'h0;
            cur.readData <= 32'h00000000;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Zero-wait slave with OKAY only; unmapped reads return zero.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = cur.readData;
    assign gateDrive = cur.gate;
    assign testStimulus = cur.testDrive;
    assign safetyChannelMismatchAlarm = cur.alarm;
    assign safeTorqueRemoval = (cur.gate == '0) & effective;
    assign irq = |(cur.irqStatus & cur.irqMask);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    gate_needs_both_a: assert property (
        effective && !bothHigh |=> gateDrive == '0)
        else $error("Gate drive on without both inputs high.");

    mismatch_raise_a: assert property (
        effective && (inA != inB) |=> safetyChannelMismatchAlarm && gateDrive == '0)
        else $error("Mismatch did not raise alarm and cut outputs.");

    selftest_restart_a: assert property (
        bothRise |=> testStimulus && cur.fsm == SELF_TEST_HIGH && !cur.testPassed)
        else $error("Both-inputs rise did not restart the self-test.");

    selftest_hold_a: assert property (
        $rose(testStimulus) |-> testStimulus [*8])
        else $error("Self-test drive phase ended too early.");

    energize_after_pass_a: assert property (
        $past(effective) && gateDrive != '0 |-> $past(cur.fsm) == RUN && $past(cur.testPassed))
        else $error("Power stage energized without a passed self-test.");

    failure_cuts_a: assert property (
        effective && cur.fsm == TEST_FAILED |=> gateDrive == '0 ##1
        (!$past(effective) || gateDrive == '0))
        else $error("Failed interlock left the power stage on.");

    bypass_passes_a: assert property (
        !effective |=> !safetyChannelMismatchAlarm && gateDrive == $past(gateCommand))
        else $error("Bypassed interlock still acted on the inputs.");

    float_all_off_a: assert property (
        $fell(permit) |=> gateDrive == '0)
        else $error("Torque removal left a gate drive active.");

    alarm_clears_a: assert property (
        safetyChannelMismatchAlarm && inA == inB |=> !safetyChannelMismatchAlarm)
        else $error("Alarm not cleared once inputs agree.");

    irq_follows_a: assert property (
        $rose(safetyChannelMismatchAlarm) && cur.irqMask[`IRQ_MISMATCH_BIT] && !readIrq
        |=> irq)
        else $error("Unmasked mismatch event did not raise the interrupt.");

endmodule

// ===== verif/safety_circuit_model.sv
// Behavioural model of the external safety circuit that drives the interlock.
// Assumes the bench changes its requests just after a rising clock edge.
`timescale 1ns/1ps

module safety_circuit_model (
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic wantA,
    input wire logic wantB,
    input wire logic wantJumper,
    input wire logic breakEcho,
    // Interlock side
    input wire logic testStimulus,
    output logic safetyInputA,
    output logic safetyInputB,
    output logic bypassJumperFitted,
    output logic testEcho
);
    // -----------------------------------------------------------------
    // Line drivers
    // -----------------------------------------------------------------
    // Both channels move on the same edge, so a requested pair rise is simultaneous.
    // A broken path holds the echo low, which a healthy interlock must catch.
    // The lines settle on the first edge, well inside the bench's reset.
    always @(posedge clk) begin
        safetyInputA <= wantA;
        safetyInputB <= wantB;
        bypassJumperFitted <= wantJumper;
        testEcho <= breakEcho ? 1'b0 : testStimulus;
    end
endmodule

// ===== verif/dual_channel_torque_off_interlock_tb_top.sv
// Self-checking bench for the torque-off interlock, driving its AHB-Lite registers.
// Assumes the safety circuit model and interlock_cfg.svh are available.
`timescale 1ns/1ps
`include "interlock_cfg.svh"

module dual_channel_torque_off_interlock_tb_top;
    import interlock_pkg::*;
    logic clk, reset_n, wantA, wantB, wantJumper, breakEcho;
    logic safetyInputA, safetyInputB, bypassJumperFitted, testStimulus, testEcho;
    gate_t gateCommand, gateDrive;
    logic safeTorqueRemoval, safetyChannelMismatchAlarm, hsel, hwrite, hready, hreadyout;
    logic hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int err_total, n_tests;

    assign hready = hreadyout;

    // -----------------------------------------------------------------
    // Instances
    // -----------------------------------------------------------------
    safety_circuit_model safety_circuit_model_inst (.clk(clk), .wantA(wantA), .wantB(wantB),
        .wantJumper(wantJumper), .breakEcho(breakEcho), .testStimulus(testStimulus),
        .safetyInputA(safetyInputA), .safetyInputB(safetyInputB),
        .bypassJumperFitted(bypassJumperFitted), .testEcho(testEcho));
    dual_channel_torque_off_interlock dual_channel_torque_off_interlock_inst (.clk(clk),
        .reset_n(reset_n), .safetyInputA(safetyInputA), .safetyInputB(safetyInputB),
        .bypassJumperFitted(bypassJumperFitted), .testStimulus(testStimulus),
        .testEcho(testEcho), .gateCommand(gateCommand), .gateDrive(gateDrive),
        .safeTorqueRemoval(safeTorqueRemoval),
        .safetyChannelMismatchAlarm(safetyChannelMismatchAlarm), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    // Closing report; the only place the run ends.
    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compare one value and count it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Wait edges, then let their updates land before anything is sampled.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait for hready sampled high at a rising edge.
    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            k++;
            if (k > 50) begin
                err_total++;
                close_out();
            end
            @(posedge clk);
        end
    endtask

    // One single-word transfer; read data is taken at the edge closing the data phase.
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdv);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask

    // Move both channels on one edge.
    task automatic pair(input logic a, input logic b);
        @(posedge clk);
        wantA <= a;
        wantB <= b;
    endtask

    // -----------------------------------------------------------------
    // Stimulus
    // -----------------------------------------------------------------
    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Main sequence; each test holds the state left by the one before.
    initial begin
        err_total = 0;
        n_tests = 0;
        reset_n = 1'b0;
        {wantA, wantB, wantJumper, breakEcho} = 4'h0;
        gateCommand = 6'h15;
        {hsel, hwrite} = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        tick(2);
        chk("power-up test drive", 32'h1, {31'h0, testStimulus});
        @(posedge clk);
        gateCommand <= 6'h2A;
        tick(2);
        chk("bypassed gates", 32'h2A, {26'h0, gateDrive});
        bus(1'b0, `ADDR_CONTROL, 32'h0, rd);
        chk("control reset", 32'h0, rd);
        bus(1'b0, `ADDR_IRQ_MASK, 32'h0, rd);
        chk("mask reset", 32'h0, rd);
        bus(1'b1, 32'h14, 32'h1, rd);
        bus(1'b0, 32'h10, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        bus(1'b0, `ADDR_CONTROL, 32'h0, rd);
        chk("control kept", 32'h0, rd);
        $display("test reset and bypass done");

        bus(1'b1, `ADDR_CONTROL, 32'h1, rd);
        bus(1'b1, `ADDR_IRQ_MASK, 32'h7, rd);
        tick(4);
        chk("gates inputs low", 32'h0, {26'h0, gateDrive});
        chk("torque removal", 32'h1, {31'h0, safeTorqueRemoval});
        bus(1'b0, `ADDR_IRQ_STATUS, 32'h0, rd);
        chk("permit fell event", 32'h4, rd);
        tick(1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        pair(1'b1, 1'b1);
        tick(260);
        chk("gates running", 32'h2A, {26'h0, gateDrive});
        @(posedge clk);
        gateCommand <= 6'h15;
        tick(1);
        chk("gate lag", 32'h15, {26'h0, gateDrive});
        bus(1'b0, `ADDR_STATUS, 32'h0, rd);
        chk("status run", 32'h65, rd & 32'h7F);
        $display("test enable and run done");

        pair(1'b1, 1'b0);
        tick(6);
        chk("alarm A only", 32'h1, {31'h0, safetyChannelMismatchAlarm});
        chk("gates A only", 32'h0, {26'h0, gateDrive});
        chk("floating", 32'h1, {31'h0, safeTorqueRemoval});
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b0, `ADDR_STATUS, 32'h0, rd);
        chk("status synced", 32'h22, rd & 32'h63);
        bus(1'b0, `ADDR_IRQ_STATUS, 32'h0, rd);
        chk("mismatch events", 32'h5, rd);
        tick(1);
        chk("irq after read", 32'h0, {31'h0, irq});
        chk("alarm held", 32'h1, {31'h0, safetyChannelMismatchAlarm});
        pair(1'b0, 1'b0);
        tick(6);
        chk("alarm cleared", 32'h0, {31'h0, safetyChannelMismatchAlarm});
        bus(1'b1, `ADDR_IRQ_MASK, 32'h2, rd);
        pair(1'b0, 1'b1);
        tick(6);
        chk("alarm B only", 32'h1, {31'h0, safetyChannelMismatchAlarm});
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, `ADDR_IRQ_MASK, 32'h7, rd);
        tick(1);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        bus(1'b0, `ADDR_IRQ_STATUS, 32'h0, rd);
        chk("B only event", 32'h1, rd);
        pair(1'b0, 1'b0);
        tick(6);
        $display("test mismatch done");

        @(posedge clk);
        breakEcho <= 1'b1;
        pair(1'b1, 1'b1);
        tick(260);
        chk("gates test failed", 32'h0, {26'h0, gateDrive});
        bus(1'b0, `ADDR_STATUS, 32'h0, rd);
        chk("failed flag", 32'h8, rd & 32'h8);
        bus(1'b0, `ADDR_IRQ_STATUS, 32'h0, rd);
        chk("fail event", 32'h2, rd & 32'h2);
        @(posedge clk);
        breakEcho <= 1'b0;
        pair(1'b0, 1'b0);
        tick(6);
        pair(1'b1, 1'b1);
        tick(260);
        chk("gates retested", 32'h15, {26'h0, gateDrive});
        $display("test self-test fault done");

        @(posedge clk);
        wantJumper <= 1'b1;
        wantB <= 1'b0;
        tick(6);
        chk("jumper alarm", 32'h0, {31'h0, safetyChannelMismatchAlarm});
        chk("jumper gates", 32'h15, {26'h0, gateDrive});
        chk("jumper removal", 32'h0, {31'h0, safeTorqueRemoval});
        $display("test jumper done");
        close_out();
    end
endmodule
